// file: hdl/tx_pdo_mapping_scheduler.sv
// Transmit mapping scheduler with APB register file.
`timescale 1ns/1ps
module tx_pdo_mapping_scheduler
  import tx_pdo_pkg::*;
#(
  parameter int TICK_P = TICK_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] node_id,
  input wire logic nmt_operational,
  input wire logic comm_restart,
  input wire logic sync_pulse,
  input wire logic [7:0] sync_count,
  input wire logic rtr_pulse,
  input wire logic [10:0] rtr_id,
  input wire logic [NUM_MAP-1:0] data_changed,
  output logic [15:0] obj_index,
  output logic [7:0] obj_subindex,
  input wire logic [31:0] obj_value,
  output logic tx_valid,
  input wire logic tx_ready,
  output frame_t tx_frame
);
  logic [NUM_MAP-1:0] cob_off_r;
  logic [10:0] cob_id_r [NUM_MAP];
  logic [10:0] act_id_r [NUM_MAP];
  logic [7:0] ttype_r [NUM_MAP];
  logic [15:0] inh_r [NUM_MAP];
  logic [7:0] compat_r [NUM_MAP];
  logic [15:0] evt_r [NUM_MAP];
  logic [7:0] sstart_r [NUM_MAP];
  logic [3:0] count_r [NUM_MAP];
  logic [31:0] ent_r [NUM_MAP][MAX_ENT];
  logic [7:0] sync_ovf_r;
  logic [63:0] payload_r [NUM_MAP];
  logic [3:0] dlc_r [NUM_MAP];
  logic [NUM_MAP-1:0] samp_req_r, send_after_r, send_req_r, has_data_r, started_r;
  logic [15:0] inh_cnt_r [NUM_MAP];
  logic [15:0] evt_cnt_r [NUM_MAP];
  logic [7:0] cyc_cnt_r [NUM_MAP];
  logic [NUM_MAP-1:0] samp_clr, send_clr, samp_done, send_ok, en, is_async, evt_exp;
  logic [NUM_MAP-1:0] cyc_fire, samp_set;
  logic oper_d_r, boot_r;
  logic [$clog2(TICK_P)-1:0] tick_cnt_r;
  logic [3:0] ms_cnt_r;
  logic tick_100us, tick_ms;
  state_t state_r;
  logic [2:0] sel_r;
  logic [3:0] k_r;
  logic [6:0] bits_r;
  logic [63:0] acc_r;
  logic wr, mapped, glob;
  logic [2:0] m;
  logic [6:0] off;
  logic [3:0] e;
  logic [7:0] len;
  logic [8:0] bits_sum;
  logic last;

  function automatic logic [2:0] first_set(input logic [NUM_MAP-1:0] v);
    first_set = 3'd0;
    for (int i = NUM_MAP - 1; i >= 0; i--) begin
      if (v[i]) first_set = 3'(i);
    end
  endfunction : first_set

  // Address decode; the slave always answers in the access cycle.
  assign m = paddr[9:7];
  assign off = paddr[6:0];
  assign e = off[5:2];
  assign glob = paddr[10];
  assign wr = psel && penable && pwrite && mapped;
  assign mapped = !paddr[11] && (paddr[1:0] == 2'b00) && (glob ?
    (paddr == OFF_SYNC_OVF || paddr == OFF_GSTAT) :
    (off <= OFF_STAT || (off >= OFF_ENT0 && e != 4'hF)));
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Configuration registers written by software.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_ovf_r <= '0;
      for (int i = 0; i < NUM_MAP; i++) begin
        cob_off_r[i] <= (i >= NUM_FIXED);
        cob_id_r[i] <= '0;
        ttype_r[i] <= DEF_TYPE;
        inh_r[i] <= '0;
        compat_r[i] <= '0;
        evt_r[i] <= '0;
        sstart_r[i] <= '0;
        count_r[i] <= (i < NUM_FIXED) ? DEF_COUNT[i] : 4'h0;
        for (int j = 0; j < MAX_ENT; j++) begin
          ent_r[i][j] <= '0;
        end
        if (i < NUM_FIXED) begin
          ent_r[i][0] <= DEF_ENT0[i];
        end
      end
      ent_r[0][1] <= DEF_MAP0_ENT1;
    end else if (wr) begin
      if (glob) begin
        if (paddr == OFF_SYNC_OVF) sync_ovf_r <= pwdata[7:0];
      end else begin
        case (off)
          OFF_COB: begin
            cob_off_r[m] <= pwdata[COB_OFF_BIT];
            if (m >= 3'(NUM_FIXED) && pwdata[10:0] != NMT_ID
                && pwdata[10:0] != SYNC_ID) begin
              cob_id_r[m] <= pwdata[10:0];
            end
          end
          OFF_TYPE: ttype_r[m] <= pwdata[7:0];
          OFF_INH: inh_r[m] <= pwdata[15:0];
          OFF_COMPAT: compat_r[m] <= pwdata[7:0];
          OFF_EVT: evt_r[m] <= pwdata[15:0];
          OFF_SSTART: sstart_r[m] <= pwdata[7:0];
          OFF_COUNT: begin
            if (pwdata[7:0] <= 8'(MAX_ENT)) count_r[m] <= pwdata[3:0];
          end
          default: begin
            if (off >= OFF_ENT0) ent_r[m][e] <= pwdata;
          end
        endcase
      end
    end
  end

  // Identifiers in use are taken over only at start-up or restart.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_r <= 1'b1;
      for (int i = 0; i < NUM_MAP; i++) act_id_r[i] <= '0;
    end else begin
      boot_r <= 1'b0;
      if (boot_r || comm_restart) begin
        for (int i = 0; i < NUM_MAP; i++) begin
          act_id_r[i] <= (i < NUM_FIXED) ? FIXED_BASE[i] + 11'(node_id)
                                         : cob_id_r[i];
        end
      end
    end
  end

  // Read multiplexer.
  always_comb begin
    prdata = '0;
    if (psel && mapped) begin
      if (glob) begin
        prdata = (paddr == OFF_SYNC_OVF) ? {24'h0, sync_ovf_r}
                                         : {28'h0, 1'b0, sel_r};
        if (paddr == OFF_GSTAT) prdata[8] = (state_r != S_IDLE);
      end else begin
        case (off)
          OFF_MAXSUB: prdata = {24'h0, COMM_MAX_SUB};
          OFF_COB: prdata = {cob_off_r[m], 20'h0, (m < 3'(NUM_FIXED)) ?
            FIXED_BASE[m[1:0]] + 11'(node_id) : cob_id_r[m]};
          OFF_TYPE: prdata = {24'h0, ttype_r[m]};
          OFF_INH: prdata = {16'h0, inh_r[m]};
          OFF_COMPAT: prdata = {24'h0, compat_r[m]};
          OFF_EVT: prdata = {16'h0, evt_r[m]};
          OFF_SSTART: prdata = {24'h0, sstart_r[m]};
          OFF_COUNT: prdata = {28'h0, count_r[m]};
          OFF_STAT: prdata = {send_req_r[m], samp_req_r[m], |inh_cnt_r[m],
            has_data_r[m], started_r[m], en[m], 11'h0, dlc_r[m], act_id_r[m]};
          default: prdata = ent_r[m][e];
        endcase
      end
    end
  end

  // Time base: a 100 us tick and a millisecond tick.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
      ms_cnt_r <= '0;
      oper_d_r <= 1'b0;
    end else begin
      oper_d_r <= nmt_operational;
      tick_cnt_r <= tick_100us ? '0 : tick_cnt_r + 1'b1;
      if (tick_100us) ms_cnt_r <= tick_ms ? '0 : ms_cnt_r + 1'b1;
    end
  end
  assign tick_100us = (tick_cnt_r == ($clog2(TICK_P))'(TICK_P - 1));
  assign tick_ms = tick_100us && (ms_cnt_r == 4'(MS_TICKS - 1));

  // Per-mapping triggers, timers and request flags.
  for (genvar i = 0; i < NUM_MAP; i++) begin : g_map
    logic [7:0] tt;
    logic event_any, sync_ok, rtr_hit, now_set, send_set;
    assign tt = ttype_r[i];
    assign en[i] = !cob_off_r[i] && count_r[i] != 0 && nmt_operational;
    assign is_async[i] = (tt >= TT_EVT_A);
    assign evt_exp[i] = en[i] && tick_ms && evt_r[i] != 0 && evt_cnt_r[i] <= 16'd1;
    assign event_any = en[i] && ((nmt_operational && !oper_d_r)
                       || data_changed[i] || evt_exp[i]);
    assign sync_ok = en[i] && sync_pulse && (started_r[i] || sync_ovf_r <= 8'd1
                     || sync_count == sstart_r[i]);
    assign rtr_hit = en[i] && rtr_pulse && rtr_id == act_id_r[i];
    assign cyc_fire[i] = sync_ok && tt != TT_ACYC && tt <= TT_CYC_MAX
                         && (cyc_cnt_r[i] + 8'd1 >= tt);
    assign now_set = cyc_fire[i] || (rtr_hit && tt == TT_RTR_EVT)
                     || (event_any && tt >= TT_EVT_A);
    assign samp_set[i] = now_set || (sync_ok && (tt == TT_ACYC
                         || tt == TT_RTR_SYNC));
    assign send_set = (event_any && tt == TT_ACYC) || (rtr_hit && tt == TT_RTR_SYNC);
    assign send_ok[i] = send_req_r[i] && en[i] && has_data_r[i]
                        && (!is_async[i] || inh_cnt_r[i] == 0);

    // Flags: a set in the same cycle as a clear wins.
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        samp_req_r[i] <= 1'b0;
        send_after_r[i] <= 1'b0;
        send_req_r[i] <= 1'b0;
        started_r[i] <= 1'b0;
      end else if (!en[i]) begin
        samp_req_r[i] <= 1'b0;
        send_after_r[i] <= 1'b0;
        send_req_r[i] <= 1'b0;
        started_r[i] <= 1'b0;
      end else begin
        if (sync_ok) started_r[i] <= 1'b1;
        if (samp_clr[i]) samp_req_r[i] <= 1'b0;
        if (samp_set[i]) samp_req_r[i] <= 1'b1;
        if (samp_set[i]) send_after_r[i] <= now_set || (send_after_r[i] && !samp_clr[i]);
        else if (samp_done[i]) send_after_r[i] <= 1'b0;
        if (send_clr[i]) send_req_r[i] <= 1'b0;
        if (send_set || (samp_done[i] && send_after_r[i])) send_req_r[i] <= 1'b1;
      end
    end

    // Event timer counts down in ms and reloads when it expires or while the mapping is disabled.
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        evt_cnt_r[i] <= '0;
        cyc_cnt_r[i] <= '0;
        inh_cnt_r[i] <= '0;
      end else begin
        if (!en[i] || evt_r[i] == 0) evt_cnt_r[i] <= evt_r[i];
        else if (evt_exp[i]) evt_cnt_r[i] <= evt_r[i];
        else if (tick_ms) evt_cnt_r[i] <= evt_cnt_r[i] - 16'd1;
        if (!en[i]) cyc_cnt_r[i] <= '0;
        else if (sync_ok && tt != TT_ACYC && tt <= TT_CYC_MAX) begin
          cyc_cnt_r[i] <= cyc_fire[i] ? 8'd0 : cyc_cnt_r[i] + 8'd1;
        end
        if (send_clr[i] && is_async[i]) inh_cnt_r[i] <= inh_r[i];
        else if (tick_100us && inh_cnt_r[i] != 0) inh_cnt_r[i] <= inh_cnt_r[i] - 16'd1;
      end
    end
  end

  // Scheduler strobes.
  assign len = ent_r[sel_r][k_r][7:0];
  assign bits_sum = {2'b00, bits_r} + {1'b0, len};
  assign last = (k_r + 4'd1 >= count_r[sel_r]) || (bits_sum > 9'(PAY_BITS));
  assign samp_clr = (state_r == S_IDLE && |samp_req_r)
                    ? NUM_MAP'(1) << first_set(samp_req_r) : '0;
  assign send_clr = (state_r == S_SEND && tx_ready) ? NUM_MAP'(1) << sel_r : '0;
  assign samp_done = (state_r == S_READ && last) ? NUM_MAP'(1) << sel_r : '0;
  assign tx_valid = (state_r == S_SEND);

  // Sampling walks the entries; sending holds the frame until taken.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      sel_r <= '0;
      k_r <= '0;
      bits_r <= '0;
      acc_r <= '0;
      obj_index <= '0;
      obj_subindex <= '0;
      tx_frame <= '0;
      has_data_r <= '0;
      for (int i = 0; i < NUM_MAP; i++) begin
        payload_r[i] <= '0;
        dlc_r[i] <= '0;
      end
    end else begin
      case (state_r)
        S_IDLE: begin
          if (|samp_req_r) begin
            sel_r <= first_set(samp_req_r);
            k_r <= '0;
            bits_r <= '0;
            acc_r <= '0;
            obj_index <= ent_r[first_set(samp_req_r)][0][31:16];
            obj_subindex <= ent_r[first_set(samp_req_r)][0][15:8];
            state_r <= S_READ;
          end else if (|send_ok) begin
            sel_r <= first_set(send_ok);
            tx_frame <= {act_id_r[first_set(send_ok)], dlc_r[first_set(send_ok)],
                         payload_r[first_set(send_ok)]};
            state_r <= S_SEND;
          end
        end
        S_READ: begin
          if (bits_sum <= 9'(PAY_BITS) && obj_index > DUMMY_MAX) begin
            acc_r <= acc_r | (({32'h0, obj_value}
                     & ((64'h1 << len) - 64'h1)) << bits_r);
          end
          if (bits_sum <= 9'(PAY_BITS)) bits_r <= bits_sum[6:0];
          if (last) begin
            payload_r[sel_r] <= (bits_sum <= 9'(PAY_BITS) && obj_index > DUMMY_MAX)
              ? acc_r | (({32'h0, obj_value} & ((64'h1 << len) - 64'h1)) << bits_r)
              : acc_r;
            dlc_r[sel_r] <= (bits_sum <= 9'(PAY_BITS)) ? 4'((bits_sum + 9'd7) >> 3)
                                                      : 4'((bits_r + 7'd7) >> 3);
            has_data_r[sel_r] <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            k_r <= k_r + 4'd1;
            obj_index <= ent_r[sel_r][k_r + 4'd1][31:16];
            obj_subindex <= ent_r[sel_r][k_r + 4'd1][15:8];
          end
        end
        S_SEND: begin
          if (tx_ready) state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_fixed_id;
    $past(comm_restart) |-> act_id_r[0] == FIXED_BASE[0] + 11'($past(node_id));
  endproperty
  a_fixed_id: assert property (p_fixed_id) else $error("fixed id wrong");
  property p_id_late;
    !comm_restart && !boot_r |=> $stable(act_id_r[4]);
  endproperty
  a_id_late: assert property (p_id_late) else $error("id changed early");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame);
  endproperty
  a_hold: assert property (p_hold) else $error("frame not held");
  property p_dlc;
    tx_valid |-> tx_frame.dlc <= 4'd8;
  endproperty
  a_dlc: assert property (p_dlc) else $error("payload too long");
  property p_inh;
    send_clr[4] && ttype_r[4] >= TT_EVT_A |=> inh_cnt_r[4] == $past(inh_r[4]);
  endproperty
  a_inh: assert property (p_inh) else $error("inhibit not loaded");
  property p_inh_block;
    inh_cnt_r[4] != 0 && ttype_r[4] >= TT_EVT_A |-> !send_ok[4];
  endproperty
  a_inh_block: assert property (p_inh_block) else $error("inhibit ignored");
  property p_timer;
    evt_exp[1] && en[1] |=> evt_cnt_r[1] == $past(evt_r[1]);
  endproperty
  a_timer: assert property (p_timer) else $error("timer not reloaded");
  property p_cyc1;
    cyc_fire[2] && ttype_r[2] == 8'h01 |=> samp_req_r[2] && send_after_r[2];
  endproperty
  a_cyc1: assert property (p_cyc1) else $error("sync send missed");
  property p_off;
    count_r[0] == 0 |=> !samp_req_r[0] && !send_req_r[0];
  endproperty
  a_off: assert property (p_off) else $error("disabled map active");
  property p_err;
    psel && penable && !mapped |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not flagged");
  c_send: cover property (tx_valid && tx_ready);
  c_read: cover property (state_r == S_READ && last);
  c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
endmodule : tx_pdo_mapping_scheduler

// file: hdl/tx_pdo_pkg.sv
// Constants and types for the transmit mapping scheduler.
package tx_pdo_pkg;
  localparam int NUM_MAP = 8;
  localparam int NUM_FIXED = 4;
  localparam int MAX_ENT = 15;
  localparam int CLK_NS = 8;
  localparam int INH_UNIT_NS = 100_000;
  localparam int MS_NS = 1_000_000;
  localparam int TICK_CYC = (INH_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_TICKS = MS_NS / INH_UNIT_NS;
  localparam int PAY_BITS = 64;
  localparam int COB_OFF_BIT = 31;
  localparam logic [6:0] OFF_MAXSUB = 7'h00;
  localparam logic [6:0] OFF_COB = 7'h04;
  localparam logic [6:0] OFF_TYPE = 7'h08;
  localparam logic [6:0] OFF_INH = 7'h0C;
  localparam logic [6:0] OFF_COMPAT = 7'h10;
  localparam logic [6:0] OFF_EVT = 7'h14;
  localparam logic [6:0] OFF_SSTART = 7'h18;
  localparam logic [6:0] OFF_COUNT = 7'h1C;
  localparam logic [6:0] OFF_STAT = 7'h20;
  localparam logic [6:0] OFF_ENT0 = 7'h40;
  localparam logic [11:0] OFF_SYNC_OVF = 12'h400;
  localparam logic [11:0] OFF_GSTAT = 12'h404;
  localparam logic [7:0] COMM_MAX_SUB = 8'h06;
  localparam logic [7:0] TT_ACYC = 8'h00;
  localparam logic [7:0] TT_CYC_MAX = 8'hF0;
  localparam logic [7:0] TT_RTR_SYNC = 8'hFC;
  localparam logic [7:0] TT_RTR_EVT = 8'hFD;
  localparam logic [7:0] TT_EVT_A = 8'hFE;
  localparam logic [7:0] DEF_TYPE = 8'hFF;
  localparam logic [15:0] DUMMY_MAX = 16'h0007;
  localparam logic [10:0] NMT_ID = 11'h000;
  localparam logic [10:0] SYNC_ID = 11'h080;
  localparam logic [10:0] FIXED_BASE [NUM_FIXED] = '{11'h180, 11'h280, 11'h380, 11'h480};
  localparam logic [3:0] DEF_COUNT [NUM_FIXED] = '{4'h2, 4'h1, 4'h1, 4'h1};
  localparam logic [31:0] DEF_ENT0 [NUM_FIXED] =
    '{32'h6041_0010, 32'h6064_0020, 32'h6044_0010, 32'h60FD_0020};
  localparam logic [31:0] DEF_MAP0_ENT1 = 32'h6061_0008;
  typedef enum {S_IDLE, S_READ, S_SEND} state_t;
  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } frame_t;
endpackage : tx_pdo_pkg

// file: verification/obj_dict_model.sv
// Object dictionary stand-in that answers the scheduler's object reads.
`timescale 1ns/1ps
module obj_dict_model (
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_subindex,
  output logic [31:0] obj_value
);
  // The value is a fixed pattern of the address, answered in the same cycle.
  assign obj_value = {obj_index[7:0] ^ 8'hC3, obj_subindex, obj_index};
endmodule : obj_dict_model

// file: verification/test_tx_pdo_mapping_scheduler.sv
// Self-checking bench for the transmit mapping scheduler.
`timescale 1ns/1ps
module test_tx_pdo_mapping_scheduler;
  import tx_pdo_pkg::*;
  localparam logic [6:0] NODE = 7'h05;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, err;
  logic nmt_operational, comm_restart, sync_pulse, rtr_pulse, tx_valid, tx_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, obj_value, rd, v, w;
  logic [7:0] sync_count, obj_subindex;
  logic [10:0] rtr_id;
  logic [NUM_MAP-1:0] data_changed;
  logic [15:0] obj_index;
  frame_t tx_frame;
  int bad_count, total_checks;

  tx_pdo_mapping_scheduler #(.TICK_P(10)) u_tx_pdo_mapping_scheduler (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .node_id(NODE), .nmt_operational(nmt_operational),
    .comm_restart(comm_restart), .sync_pulse(sync_pulse), .sync_count(sync_count),
    .rtr_pulse(rtr_pulse), .rtr_id(rtr_id), .data_changed(data_changed),
    .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_value(obj_value),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame)
  );

  obj_dict_model u_obj_dict_model (
    .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_value(obj_value)
  );

  // Free-running clock at 125 MHz.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Expected object value, subindex zero.
  function automatic logic [31:0] ov(input logic [15:0] idx);
    return {idx[7:0] ^ 8'hC3, 8'h00, idx};
  endfunction : ov

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Compares a seen value with the expected one and counts it.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      $display("Error at %0t: no ready", $time);
      complete_run();
    end
  endtask : apb

  // Reads a register and compares it.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check({32'h0000_0000, rd}, {32'h0000_0000, exp});
  endtask : rd_chk

  // One-cycle pulse: 0 SYNC, 1 remote request, 2 data change, else restart.
  task automatic ev(input int kind, input logic [10:0] x);
    @(posedge clock);
    case (kind)
      0: sync_pulse <= 1'b1;
      1: begin
        rtr_pulse <= 1'b1;
        rtr_id <= x;
      end
      2: data_changed <= 8'h01 << x[2:0];
      default: comm_restart <= 1'b1;
    endcase
    @(posedge clock);
    sync_pulse <= 1'b0;
    rtr_pulse <= 1'b0;
    data_changed <= '0;
    comm_restart <= 1'b0;
  endtask : ev

  // Waits for a frame, stalls, compares it, then takes it.
  task automatic get_frame(input logic [10:0] id, input logic [3:0] dlc,
                           input logic [63:0] d, input int stall);
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      $display("Error at %0t: no frame", $time);
      complete_run();
    end
    repeat (stall) begin
      @(posedge clock);
      #1;
    end
    check({53'h0, tx_frame.id}, {53'h0, id});
    check({60'h0, tx_frame.dlc}, {60'h0, dlc});
    check(tx_frame.data, d);
    @(posedge clock);
    tx_ready <= 1'b1;
    @(posedge clock);
    tx_ready <= 1'b0;
    #1;
  endtask : get_frame

  // No frame may be offered for n cycles.
  task automatic quiet(input int n);
    int seen;
    seen = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (tx_valid !== 1'b0) seen++;
    end
    check(64'(seen), 64'h0);
  endtask : quiet

  // Main sequence.
  initial begin
    bad_count = 0;
    total_checks = 0;
    rst = 1'b1;
    {psel, penable, pwrite, nmt_operational, comm_restart} = '0;
    {sync_pulse, rtr_pulse, tx_ready} = '0;
    paddr = '0;
    pwdata = '0;
    sync_count = '0;
    rtr_id = '0;
    data_changed = '0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd_chk(12'h000, 32'h0000_0006);
    for (int k = 0; k < 4; k++) begin
      rd_chk(12'(k * 128 + 4), 32'(32'h180 + k * 256 + NODE));
      rd_chk(12'(k * 128 + 28), (k == 0) ? 32'h2 : 32'h1);
    end
    rd_chk(12'h040, 32'h6041_0010);
    rd_chk(12'h044, 32'h6061_0008);
    rd_chk(12'h0C0, 32'h6064_0020);
    rd_chk(12'h140, 32'h6044_0010);
    rd_chk(12'h1C0, 32'h60FD_0020);
    apb(1'b1, 12'h004, 32'h0000_0123);
    rd_chk(12'h004, 32'h0000_0185);
    apb(1'b1, 12'h004, 32'h8000_0000);
    rd_chk(12'h004, 32'h8000_0185);
    apb(1'b1, 12'h004, 32'h0000_0000);
    apb(1'b0, 12'h800, 32'h0000_0000);
    check({63'h0, err}, 64'h1);
    $display("Test registers done");
    // Mapping five reconfigured in the documented order.
    apb(1'b1, 12'h204, 32'h8000_01A5);
    apb(1'b1, 12'h21C, 32'h0000_0000);
    apb(1'b1, 12'h240, 32'h6064_0020);
    apb(1'b1, 12'h21C, 32'h0000_0001);
    apb(1'b1, 12'h208, 32'h0000_00FF);
    apb(1'b1, 12'h204, 32'h0000_01A5);
    apb(1'b0, 12'h220, 32'h0000_0000);
    check({63'h0, rd[10:0] == 11'h1A5}, 64'h0);
    ev(3, 11'h000);
    apb(1'b0, 12'h220, 32'h0000_0000);
    check({53'h0, rd[10:0]}, 64'h1A5);
    $display("Test identifier done");
    @(posedge clock);
    nmt_operational <= 1'b1;
    v = ov(16'h6041);
    w = ov(16'h6061);
    get_frame(11'h185, 4'd3, {40'h0, w[7:0], v[15:0]}, 3);
    get_frame(11'h285, 4'd4, {32'h0, ov(16'h6064)}, 0);
    v = ov(16'h6044);
    get_frame(11'h385, 4'd2, {48'h0, v[15:0]}, 0);
    get_frame(11'h485, 4'd4, {32'h0, ov(16'h60FD)}, 0);
    get_frame(11'h1A5, 4'd4, {32'h0, ov(16'h6064)}, 0);
    $display("Test operational done");
    apb(1'b1, 12'h400, 32'h0000_0004);
    apb(1'b1, 12'h118, 32'h0000_0003);
    apb(1'b1, 12'h108, 32'h0000_0001);
    sync_count <= 8'h02;
    ev(0, 11'h000);
    quiet(30);
    sync_count <= 8'h03;
    for (int k = 0; k < 2; k++) begin
      ev(0, 11'h000);
      get_frame(11'h385, 4'd2, {48'h0, v[15:0]}, 0);
    end
    apb(1'b1, 12'h108, 32'h0000_00FF);
    apb(1'b1, 12'h400, 32'h0000_0000);
    apb(1'b1, 12'h088, 32'h0000_0000);
    ev(0, 11'h000);
    quiet(30);
    ev(2, 11'h001);
    get_frame(11'h285, 4'd4, {32'h0, ov(16'h6064)}, 0);
    apb(1'b1, 12'h188, 32'h0000_00FD);
    ev(1, 11'h485);
    get_frame(11'h485, 4'd4, {32'h0, ov(16'h60FD)}, 0);
    apb(1'b1, 12'h188, 32'h0000_00FC);
    ev(0, 11'h000);
    quiet(30);
    ev(1, 11'h485);
    get_frame(11'h485, 4'd4, {32'h0, ov(16'h60FD)}, 0);
    $display("Test types done");
    apb(1'b1, 12'h01C, 32'h0000_0000);
    ev(2, 11'h000);
    quiet(30);
    apb(1'b1, 12'h20C, 32'h0000_0003);
    ev(2, 11'h004);
    get_frame(11'h1A5, 4'd4, {32'h0, ov(16'h6064)}, 0);
    ev(2, 11'h004);
    quiet(15);
    get_frame(11'h1A5, 4'd4, {32'h0, ov(16'h6064)}, 0);
    apb(1'b1, 12'h088, 32'h0000_00FF);
    apb(1'b1, 12'h094, 32'h0000_0001);
    get_frame(11'h285, 4'd4, {32'h0, ov(16'h6064)}, 0);
    get_frame(11'h285, 4'd4, {32'h0, ov(16'h6064)}, 0);
    apb(1'b1, 12'h094, 32'h0000_0000);
    $display("Test timing done");
    complete_run();
  end
endmodule : test_tx_pdo_mapping_scheduler
